// ---- core/fprc_pkg.sv ----
package fprc_pkg;
  // Clock and bus geometry
  localparam int CLK_HZ = 25_000_000;
  localparam int ADDR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MANUAL_DUTY0 = 8'h30;
  localparam logic [7:0] IDX_LOCK = 8'h40;
  localparam logic [7:0] IDX_OUT_CFG0 = 8'h5c;
  localparam logic [7:0] IDX_ACOUSTIC = 8'h62;
  localparam logic [7:0] IDX_MIN_DUTY0 = 8'h64;
  localparam logic [7:0] IDX_RAMP_STATUS = 8'h68;
  // Reset values
  localparam logic [7:0] ACOUSTIC_RST = 8'h00;
  localparam logic [7:0] OUT_CFG_RST = 8'h62;
  localparam logic [7:0] MIN_DUTY_RST = 8'h80;
  localparam logic [7:0] MANUAL_DUTY_RST = 8'h00;
  // Field positions of the acoustic register
  localparam int RATE_LSB = 0;
  localparam int RATE_MSB = 2;
  localparam int RAMP_EN_BIT = 3;
  localparam int RSVD_BIT = 4;
  localparam int FLOOR_LSB = 5;
  localparam logic [7:0] ACOUSTIC_WMASK = 8'hef;
  // Field positions of each output configuration register and of the lock register
  localparam int SPIN_LSB = 0;
  localparam int SPIN_MSB = 2;
  localparam int MODE_LSB = 5;
  localparam int MODE_MSB = 7;
  localparam int LOCK_BIT = 0;
  // Behaviour modes of one output
  typedef enum logic [2:0] {
    MODE_REMOTE1 = 3'h0, MODE_LOCAL = 3'h1, MODE_REMOTE2 = 3'h2, MODE_FULL = 3'h3,
    MODE_OFF = 3'h4, MODE_MAX_LR2 = 3'h5, MODE_MAX_ALL = 3'h6, MODE_MANUAL = 3'h7
  } fprc_mode_type;
  // Duty levels
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] RAMP_LOW_DUTY = 8'h54;
  // Slowest ramp: one step per slot, 33 to 100 percent in this time
  localparam int RAMP_FULL_TIME_MS = 35000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int RAMP_SLOT_CYCLES = CYCLES_PER_MS * RAMP_FULL_TIME_MS / (255 - 84);
  // Startup timeouts in ms
  localparam int SPIN_MS_1 = 100;
  localparam int SPIN_MS_2 = 250;
  localparam int SPIN_MS_3 = 400;
  localparam int SPIN_MS_5 = 1000;
  localparam int SPIN_MS_6 = 2000;
  localparam int SPIN_MS_7 = 4000;
  // PWM carrier, centi-hertz, 255 ticks per period
  localparam int PWM_FREQ_CHZ = 3530;
  localparam int PWM_DIV_CYCLES = CLK_HZ / (PWM_FREQ_CHZ * 255 / 100);
  localparam logic [7:0] PWM_LAST = 8'hfe;
  // Bus handshake states
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} fprc_bus_type;
endpackage : fprc_pkg

// ---- core/fprc_top.sv ----
// Operation
// - After power-on the acoustic register reads 0x00, ramp off, floors zero.
// - Rate bits 2:0 pick step 1,2,3,5,8,12,24 or 48 per slot.
// - With ramping active the first output walks toward its new duty.
// - Slowest rate moves 33 to 100 percent in about 35 s, fastest 0.8 s.
// - Bit 3 enables ramping of the first output; zero means no limiting.
// - Bit 4 is reserved, reads zero, writes ignored.
// - Bit 5 picks off or minimum duty for first output below threshold.
// - Bit 6 picks off or minimum duty for second output below threshold.
// - Bit 7 picks off or minimum duty for third output below threshold.
// - Once the lock bit is set, the register ignores writes.
// - Behaviour bits 7:5 of each output config choose auto, full, off, manual.
// - Startup timeout bits 2:0 hold the output high; 000 means none.
`timescale 1ns/1ns
module fprc_top #(
  parameter int SLOT_CYCLES = fprc_pkg::RAMP_SLOT_CYCLES,
  parameter int MS_CYCLES = fprc_pkg::CYCLES_PER_MS,
  parameter int PWM_DIV = fprc_pkg::PWM_DIV_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [fprc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [7:0] i_auto_duty0,
  input wire logic [7:0] i_auto_duty1,
  input wire logic [7:0] i_auto_duty2,
  input wire logic [2:0] i_below_floor,
  input wire logic [2:0] i_tach_seen,
  output logic [2:0] o_pwm
);
  import fprc_pkg::*;

  // Step size per rate code
  function automatic logic [7:0] rate_step(input logic [2:0] code);
    logic [7:0] s;
    s = 8'h01;
    unique case (code)
      3'h0: s = 8'h01;
      3'h1: s = 8'h02;
      3'h2: s = 8'h03;
      3'h3: s = 8'h05;
      3'h4: s = 8'h08;
      3'h5: s = 8'h0c;
      3'h6: s = 8'h18;
      3'h7: s = 8'h30;
    endcase
    return s;
  endfunction : rate_step

  // Startup timeout in ms; the illegal code 100 is treated as none
  function automatic logic [31:0] spin_ms(input logic [2:0] code);
    logic [31:0] m;
    m = 32'h0;
    unique case (code)
      3'h1: m = 32'(SPIN_MS_1);
      3'h2: m = 32'(SPIN_MS_2);
      3'h3: m = 32'(SPIN_MS_3);
      3'h5: m = 32'(SPIN_MS_5);
      3'h6: m = 32'(SPIN_MS_6);
      3'h7: m = 32'(SPIN_MS_7);
      default: m = 32'h0;
    endcase
    return m;
  endfunction : spin_ms

  // Reset release through two flops
  logic rst_meta, rst_n;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic [7:0] acoustic, next_acoustic, ramp_duty, next_ramp_duty;
  logic [7:0] out_cfg [3], next_out_cfg [3];
  logic [7:0] min_duty [3], next_min_duty [3];
  logic [7:0] manual_duty [3], next_manual_duty [3];
  logic locked, next_locked;
  fprc_bus_type bus_state, next_bus_state;
  logic [31:0] next_readdata;
  logic [7:0] auto_duty [3], target [3], eff_duty [3];
  logic [7:0] idx;
  logic hit, bus_write;
  assign auto_duty[0] = i_auto_duty0;
  assign auto_duty[1] = i_auto_duty1;
  assign auto_duty[2] = i_auto_duty2;
  assign idx = i_avs_address[9:2];
  assign hit = (i_avs_address[1:0] == 2'b00);
  // A write commits only on the edge where the master sees waitrequest low
  assign bus_write = i_avs_write && !o_avs_waitrequest && hit && i_avs_byteenable[0];

  // Bus handshake and register writes; one wait cycle then a one-cycle answer
  always_comb begin
    next_bus_state = BUS_IDLE;
    next_readdata = o_avs_readdata;
    next_acoustic = acoustic;
    next_locked = locked;
    next_out_cfg = out_cfg;
    next_min_duty = min_duty;
    next_manual_duty = manual_duty;
    if (bus_state == BUS_IDLE && (i_avs_read || i_avs_write)) begin
      next_bus_state = BUS_ACK;
      next_readdata = 32'h0;
      if (i_avs_read && hit) begin
        for (int k = 0; k < 3; k++) begin
          if (idx == IDX_OUT_CFG0 + 8'(k)) next_readdata = {24'h0, out_cfg[k]};
          if (idx == IDX_MIN_DUTY0 + 8'(k)) next_readdata = {24'h0, min_duty[k]};
          if (idx == IDX_MANUAL_DUTY0 + 8'(k)) next_readdata = {24'h0, manual_duty[k]};
        end
        if (idx == IDX_ACOUSTIC) next_readdata = {24'h0, acoustic};
        if (idx == IDX_LOCK) next_readdata = {31'h0, locked};
        if (idx == IDX_RAMP_STATUS) next_readdata = {24'h0, ramp_duty};
      end
    end
    if (bus_write) begin
      if (!locked && idx == IDX_ACOUSTIC) begin
        next_acoustic = i_avs_writedata[7:0] & ACOUSTIC_WMASK;
      end
      // Lock is set-only; only a reset clears it
      if (idx == IDX_LOCK && i_avs_writedata[LOCK_BIT]) next_locked = 1'b1;
      for (int k = 0; k < 3; k++) begin
        if (!locked && idx == IDX_OUT_CFG0 + 8'(k)) next_out_cfg[k] = i_avs_writedata[7:0];
        if (!locked && idx == IDX_MIN_DUTY0 + 8'(k)) next_min_duty[k] = i_avs_writedata[7:0];
        if (idx == IDX_MANUAL_DUTY0 + 8'(k)) next_manual_duty[k] = i_avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
      acoustic <= ACOUSTIC_RST;
      locked <= 1'b0;
      out_cfg <= '{default: OUT_CFG_RST};
      min_duty <= '{default: MIN_DUTY_RST};
      manual_duty <= '{default: MANUAL_DUTY_RST};
    end else begin
      bus_state <= next_bus_state;
      o_avs_waitrequest <= (next_bus_state != BUS_ACK);
      o_avs_readdata <= next_readdata;
      acoustic <= next_acoustic;
      locked <= next_locked;
      out_cfg <= next_out_cfg;
      min_duty <= next_min_duty;
      manual_duty <= next_manual_duty;
    end
  end

  // Target duty per output from behaviour mode and floor selects
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      unique case (fprc_mode_type'(out_cfg[k][MODE_MSB:MODE_LSB]))
        MODE_FULL: target[k] = DUTY_FULL;
        MODE_OFF: target[k] = DUTY_ZERO;
        MODE_MANUAL: target[k] = manual_duty[k];
        MODE_REMOTE1, MODE_LOCAL, MODE_REMOTE2, MODE_MAX_LR2, MODE_MAX_ALL: begin
          if (i_below_floor[k]) target[k] = acoustic[FLOOR_LSB + k] ? min_duty[k] : DUTY_ZERO;
          else target[k] = auto_duty[k];
        end
      endcase
    end
  end

  // Slot divider, one enable pulse per ramp slot
  logic [31:0] slot_cnt, next_slot_cnt;
  logic slot_tick;
  assign slot_tick = (slot_cnt == 32'(SLOT_CYCLES - 1));
  logic ramp_en;
  logic [7:0] step;
  logic [8:0] sum;
  assign ramp_en = acoustic[RAMP_EN_BIT];
  assign step = rate_step(acoustic[RATE_MSB:RATE_LSB]);
  assign sum = {1'b0, ramp_duty} + {1'b0, step};

  // Ramp of the first output; slow rates exist to hide fan speed changes
  always_comb begin
    next_slot_cnt = slot_tick ? 32'h0 : slot_cnt + 32'h1;
    next_ramp_duty = ramp_duty;
    if (!ramp_en) begin
      next_ramp_duty = target[0];
    end else if (slot_tick) begin
      // one step per slot, clamped at target
      if (ramp_duty < target[0]) next_ramp_duty = (sum >= {1'b0, target[0]}) ? target[0] : sum[7:0];
      else if (ramp_duty > target[0])
        next_ramp_duty = (ramp_duty - target[0] <= step) ? target[0] : ramp_duty - step;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= 32'h0;
      ramp_duty <= DUTY_ZERO;
    end else begin
      slot_cnt <= next_slot_cnt;
      ramp_duty <= next_ramp_duty;
    end
  end

  assign eff_duty[0] = ramp_duty;
  assign eff_duty[1] = target[1];
  assign eff_duty[2] = target[2];

  // Startup: full drive from zero until timeout or two tach edges
  logic [31:0] spin_cnt [3], next_spin_cnt [3];
  logic [2:0] spinning, next_spinning, was_zero, next_was_zero, spin_start;
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      next_was_zero[k] = (eff_duty[k] == DUTY_ZERO);
      spin_start[k] = was_zero[k] && (eff_duty[k] != DUTY_ZERO);
      next_spinning[k] = spinning[k];
      next_spin_cnt[k] = spin_cnt[k];
      if (spin_start[k] && spin_ms(out_cfg[k][SPIN_MSB:SPIN_LSB]) != 32'h0) begin
        next_spinning[k] = 1'b1;
        next_spin_cnt[k] = 32'(spin_ms(out_cfg[k][SPIN_MSB:SPIN_LSB]) * 32'(MS_CYCLES));
      end else if (spinning[k]) begin
        next_spin_cnt[k] = spin_cnt[k] - 32'h1;
        if (spin_cnt[k] <= 32'h1 || i_tach_seen[k] || eff_duty[k] == DUTY_ZERO) next_spinning[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      spinning <= 3'h0;
      was_zero <= 3'h7;
      spin_cnt <= '{default: 32'h0};
    end else begin
      spinning <= next_spinning;
      was_zero <= next_was_zero;
      spin_cnt <= next_spin_cnt;
    end
  end

  // PWM carrier: 255 ticks so duty 0xff is a steady high
  logic [15:0] div_cnt, next_div_cnt;
  logic [7:0] pwm_cnt, next_pwm_cnt;
  logic [2:0] next_pwm;
  always_comb begin
    next_div_cnt = (div_cnt == 16'(PWM_DIV - 1)) ? 16'h0 : div_cnt + 16'h1;
    next_pwm_cnt = pwm_cnt;
    if (div_cnt == 16'(PWM_DIV - 1)) next_pwm_cnt = (pwm_cnt == PWM_LAST) ? 8'h00 : pwm_cnt + 8'h01;
    for (int k = 0; k < 3; k++) next_pwm[k] = spinning[k] || (eff_duty[k] > pwm_cnt);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0;
      pwm_cnt <= 8'h00;
      o_pwm <= 3'h0;
    end else begin
      div_cnt <= next_div_cnt;
      pwm_cnt <= next_pwm_cnt;
      o_pwm <= next_pwm;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_req_taken;
    (i_avs_read || i_avs_write) && bus_state == BUS_IDLE;
  endsequence
  sequence s_one_ack;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  chk_bus_answer: assert property (s_req_taken |=> s_one_ack)
    else $error("bus answer not one cycle after request");
  chk_reset_zero: assert property ($rose(rst_n) |-> acoustic == ACOUSTIC_RST)
    else $error("acoustic register not zero after reset");
  chk_rate_step: assert property (slot_tick && ramp_en && sum < {1'b0, target[0]} |=>
    ramp_duty == $past(sum[7:0]))
    else $error("ramp step size wrong");
  chk_ramp_hold: assert property (ramp_en && !slot_tick |=> ramp_duty == $past(ramp_duty))
    else $error("ramp moved outside a slot");
  // Flops still sit in reset on the edge where rst_n lifts, so start one edge later
  chk_ramp_off: assert property (rst_n && !ramp_en |=> ramp_duty == $past(target[0]))
    else $error("duty not direct with ramp off");
  chk_rsvd_zero: assert property (acoustic[RSVD_BIT] == 1'b0)
    else $error("reserved bit set");
  chk_floor_first: assert property (out_cfg[0][MODE_MSB:MODE_LSB] == 3'h0 && i_below_floor[0]
    |-> target[0] == (acoustic[5] ? min_duty[0] : 8'h00))
    else $error("first floor select wrong");
  chk_floor_second: assert property (out_cfg[1][MODE_MSB:MODE_LSB] == 3'h1 && i_below_floor[1]
    |-> target[1] == (acoustic[6] ? min_duty[1] : 8'h00))
    else $error("second floor select wrong");
  chk_floor_third: assert property (out_cfg[2][MODE_MSB:MODE_LSB] == 3'h2 && i_below_floor[2]
    |-> target[2] == (acoustic[7] ? min_duty[2] : 8'h00))
    else $error("third floor select wrong");
  chk_lock_freeze: assert property (locked |=> $stable(acoustic))
    else $error("locked register changed");
  chk_full_mode: assert property (out_cfg[1][MODE_MSB:MODE_LSB] == 3'h3 ##1 out_cfg[1][MODE_MSB:MODE_LSB] == 3'h3
    |=> o_pwm[1])
    else $error("full speed output not high");
  chk_no_spin: assert property (spin_start[0] && out_cfg[0][SPIN_MSB:SPIN_LSB] == 3'h0 |=> !spinning[0])
    else $error("spin-up with timeout code zero");
  chk_ramp_moves: assert property (ramp_en && slot_tick && ramp_duty != target[0]
    |=> ramp_duty != $past(ramp_duty))
    else $error("ramp stalled before target");
endmodule : fprc_top

// ---- sim/fprc_fan_model.sv ----
`timescale 1ns/1ns
// Fan model: reports two tach edges once its output has driven it for a while
module fprc_fan_model #(
  parameter int SPIN_CYCLES = 3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_pwm,
  output logic [2:0] o_tach_seen
);
  int cnt [3];
  // A stopped fan loses its tach, so the count restarts whenever the drive is 0
  always @(posedge i_clk or negedge i_resetn) begin
    for (int k = 0; k < 3; k++) begin
      if (!i_resetn || i_pwm[k] !== 1'b1) begin
        cnt[k] <= 0;
      end else if (cnt[k] < SPIN_CYCLES) begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_tach_seen[k] = (cnt[k] >= SPIN_CYCLES);
    end
  end
endmodule : fprc_fan_model

// ---- sim/fprc_top_tb.sv ----
`timescale 1ns/1ns
module fprc_top_tb;
  import fprc_pkg::*;
  localparam int SLOT = 8;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [7:0] duty0, duty1, duty2, w;
  logic [2:0] below, tach, pwm;
  int fails, n_checks, seed, hi;
  fprc_top #(.SLOT_CYCLES(SLOT), .MS_CYCLES(2), .PWM_DIV(1)) u_fprc_top (
    .i_clk(clk), .i_resetn(resetn), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .i_auto_duty0(duty0),
    .i_auto_duty1(duty1), .i_auto_duty2(duty2), .i_below_floor(below), .i_tach_seen(tach), .o_pwm(pwm));
  fprc_fan_model u_fprc_fan_model (.i_clk(clk), .i_resetn(resetn), .i_pwm(pwm), .o_tach_seen(tach));
  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One Avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("bus_timeout", 0, 1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Count high cycles of one PWM output over 300 clocks
  task automatic count_hi(input int k);
    hi = 0;
    repeat (300) begin
      @(posedge clk);
      if (pwm[k] === 1'b1) hi++;
    end
  endtask : count_hi
  // A 300-clock window holds one full 255-tick period plus 45 ticks of the next
  function automatic bit hi_ok(input int d, input int h);
    return h >= d && h <= d + ((d < 45) ? d : 45);
  endfunction : hi_ok
  function automatic int step_of(input logic [2:0] c);
    case (c)
      3'h0: return 1;
      3'h1: return 2;
      3'h2: return 3;
      3'h3: return 5;
      3'h4: return 8;
      3'h5: return 12;
      3'h6: return 24;
      default: return 48;
    endcase
  endfunction : step_of
  // Walk output 0 from one duty to another at a given rate and watch each read
  task automatic ramp_walk(input logic [2:0] c, input logic [7:0] from, input logic [7:0] to);
    int s, n, slots, el, d;
    logic [7:0] prev;
    realtime t0;
    s = step_of(c);
    slots = (255 + s - 1) / s;
    bus(1, IDX_ACOUSTIC, {5'h0, c});
    duty0 <= from;
    bus(0, IDX_RAMP_STATUS, 8'h0);
    chk("unramped_duty", from, rd);
    // spin-up timeout already off on every output before ramping
    bus(1, IDX_ACOUSTIC, {5'h1, c});
    duty0 <= to;
    t0 = $realtime;
    prev = from;
    n = 0;
    do begin
      bus(0, IDX_RAMP_STATUS, 8'h0);
      if (n == 0) chk("ramp_not_jump", 1, rd[7:0] != to);
      d = (to > from) ? rd[7:0] - from : from - rd[7:0];
      chk("ramp_step", 1, (rd[7:0] == to || d % s == 0) && ((to > from) ? rd[7:0] >= prev : rd[7:0] <= prev));
      prev = rd[7:0];
      n++;
    end while (rd[7:0] != to && n < 1500);
    chk("ramp_reached", {24'h0, to}, rd);
    el = int'(($realtime - t0) / 40);
    chk("ramp_time", 1, el <= slots * SLOT + 12 && el >= (slots - 1) * SLOT);
  endtask : ramp_walk
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Watchdog well beyond the longest ramp sweep
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    seed = 32'h301622c5;
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    {duty0, duty1, duty2, below} = '0;
    {fails, n_checks} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, IDX_ACOUSTIC, 8'h0);
    chk("acoustic_reset", 32'h0, rd);
    bus(0, IDX_OUT_CFG0, 8'h0);
    chk("cfg_reset", {24'h0, OUT_CFG_RST}, rd);
    bus(0, 8'h7f, 8'h0);
    chk("unmapped_read", 32'h0, rd);
    $display("test reset done");
    // Reserved bit corner first, then random patterns
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 8'h10 : 8'($random(seed));
      bus(1, IDX_ACOUSTIC, w);
      bus(0, IDX_ACOUSTIC, 8'h0);
      chk("acoustic_rw", {24'h0, w & ACOUSTIC_WMASK}, rd);
    end
    $display("test register done");
    // automatic mode, spin code 000 keeps outputs free of spin-up
    for (int k = 0; k < 3; k++) bus(1, IDX_OUT_CFG0 + 8'(k), {MODE_REMOTE1, 5'h0});
    below <= 3'h7;
    // Auto duty of outputs 1 and 2 kept well above the floor so a missing floor shows in their count
    duty1 <= 8'($random(seed)) | 8'hc0;
    duty2 <= 8'hff;
    for (int f = 0; f < 2; f++) begin
      bus(1, IDX_ACOUSTIC, {f[0], f[0], f[0], 5'h0});
      bus(0, IDX_RAMP_STATUS, 8'h0);
      chk("floor_duty0", f ? MIN_DUTY_RST : 8'h0, rd);
      for (int k = 0; k < 3; k++) begin
        count_hi(k);
        chk("floor_pwm", 1, hi_ok(f ? MIN_DUTY_RST : 8'h0, hi));
      end
    end
    below <= 3'h0;
    $display("test floor done");
    for (int i = 0; i < 6; i++) begin
      w = 8'($random(seed));
      duty0 <= w;
      bus(0, IDX_RAMP_STATUS, 8'h0);
      chk("follow_duty", {24'h0, w}, rd);
    end
    $display("test follow done");
    // Disabled mode on output 1, manual mode on output 2
    w = 8'($random(seed));
    bus(1, IDX_MANUAL_DUTY0 + 8'h2, w);
    bus(1, IDX_OUT_CFG0 + 8'h1, {MODE_OFF, 5'h0});
    bus(1, IDX_OUT_CFG0 + 8'h2, {MODE_MANUAL, 5'h0});
    repeat (4) @(posedge clk);
    count_hi(1);
    chk("off_pwm", 0, hi);
    count_hi(2);
    chk("manual_pwm", 1, hi_ok(w, hi));
    $display("test mode done");
    for (int c = 0; c < 8; c++) begin
      ramp_walk(3'(c), 8'h00, 8'hff);
      ramp_walk(3'(c), 8'hff, 8'h00);
    end
    $display("test ramp done");
    bus(1, IDX_LOCK, 8'h01);
    bus(1, IDX_ACOUSTIC, 8'h2a);
    bus(0, IDX_ACOUSTIC, 8'h0);
    chk("locked_write", 32'h0f, rd);
    bus(1, IDX_OUT_CFG0, 8'h7f);
    bus(0, IDX_OUT_CFG0, 8'h0);
    chk("locked_cfg", 32'h0, rd);
    bus(1, IDX_MANUAL_DUTY0, 8'h5a);
    bus(0, IDX_MANUAL_DUTY0, 8'h0);
    chk("manual_rw", 32'h5a, rd);
    $display("test lock done");
    // Mid-run reset clears the register and the lock
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset_wait", 1, avs_waitrequest);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, IDX_ACOUSTIC, 8'h0);
    chk("acoustic_rereset", {24'h0, ACOUSTIC_RST}, rd);
    bus(1, IDX_ACOUSTIC, 8'h2a);
    bus(0, IDX_ACOUSTIC, 8'h0);
    chk("lock_cleared", {24'h0, 8'h2a & ACOUSTIC_WMASK}, rd);
    $display("test rereset done");
    test_done();
  end
endmodule : fprc_top_tb
